// >>> design/pjsid_pkg.sv
// pjsid_pkg: offsets, field positions and reset values of the jabber
// status and identifier register bank.
// assumes a 5-bit management register address and 16-bit register data.
`default_nettype none

package pjsid_pkg;

	// register addresses on the management port
	localparam logic [4:0] REG_STATUS   = 5'h01;
	localparam logic [4:0] REG_ID_HIGH  = 5'h02;
	localparam logic [4:0] REG_ID_LOW   = 5'h03;
	localparam logic [4:0] REG_EXT_CTRL = 5'h10;
	localparam logic [4:0] REG_DETAIL   = 5'h11;
	localparam logic [4:0] REG_TEN_OPS  = 5'h12;

	// field positions
	localparam int unsigned STATUS_JAB_BIT    = 1;
	localparam int unsigned STATUS_EXTCAP_BIT = 0;
	localparam int unsigned DETAIL_JAB_BIT    = 2;
	localparam int unsigned EXT_OVERRIDE_BIT  = 15;
	localparam int unsigned TEN_JAB_EN_BIT    = 5;
	localparam int unsigned ID_HIGH_FIRST_OUI = 3;
	localparam int unsigned ID_LOW_FIRST_OUI  = 19;
	localparam int unsigned ID_LOW_OUI_BITS   = 6;

	// reset values
	localparam logic [5:0]  MODEL_RST    = 6'h04;
	localparam logic [3:0]  REV_RST      = 4'h1;
	localparam logic        OVERRIDE_RST = 1'b0;
	localparam logic        JAB_EN_RST   = 1'b1;
	localparam logic [15:0] ZERO_WORD    = 16'h0000;

endpackage : pjsid_pkg

`default_nettype wire

// >>> design/pjsid_latch_high_flag.sv
// pjsid_latch_high_flag: one latching-high status flag with an enable.
// assumes event_in and clear are single-clock signals of clk's domain.
`timescale 1ns/1ps
`default_nettype none

module pjsid_latch_high_flag (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// control
	input  wire logic enable,
	input  wire logic event_in,
	input  wire logic clear,
	// state
	output var  logic flag_q
);

	// event beats clear so a hit during a read shows up on the next one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flag_q <= 1'b0;
		end else if (!enable) begin
			flag_q <= 1'b0;
		end else if (event_in) begin
			flag_q <= 1'b1;
		end else if (clear) begin
			flag_q <= 1'b0;
		end
	end

endmodule : pjsid_latch_high_flag

`default_nettype wire

// >>> design/pjsid_regs.sv
// pjsid_regs: jabber status flag, extended-capability flag and the two
// identifier registers of the management register bank.
// assumes a management front end that issues one-cycle read and write
// strobes with address and data on clk; jabber_event comes from the
// jabber detector on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pjsid_regs
	import pjsid_pkg::*;
#(
	// vendor identifier, first octet in [23:16]; value is arbitrary
	parameter logic [23:0] OUI_VALUE = 24'h12_3456
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// management access
	input  wire logic        mgmt_rd,
	input  wire logic        mgmt_wr,
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic [15:0] mgmt_wdata,
	output logic      [15:0] mgmt_rdata,
	output logic             mgmt_rvalid,
	// jabber detector
	input  wire logic        jabber_event,
	output logic             jabber_detect_en
);

	logic        override_q;
	logic        jab_en_q;
	logic        jab_flag;
	logic        flag_clear;
	logic [15:0] id_high_q;
	logic [15:0] id_low_q;
	logic [15:0] id_high_rst;
	logic [15:0] id_low_rst;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        rvalid_q;

	// vendor bit n (1..24): octet (n-1)/8, taken least significant first
	function automatic logic oui_bit(input logic [23:0] oui,
	                                 input int unsigned n);
		int unsigned k;
		int unsigned p;
		k = (n - 1) / 8;
		p = (n - 1) % 8;
		oui_bit = oui[16 - 8 * k + p];
	endfunction : oui_bit

	// reset images of the identifier registers
	for (genvar i = 0; i < 16; i++) begin : g_id_high
		assign id_high_rst[15 - i] =
			oui_bit(OUI_VALUE, ID_HIGH_FIRST_OUI + i);
	end
	for (genvar i = 0; i < ID_LOW_OUI_BITS; i++) begin : g_id_low
		assign id_low_rst[15 - i] =
			oui_bit(OUI_VALUE, ID_LOW_FIRST_OUI + i);
	end
	assign id_low_rst[9:0] = {MODEL_RST, REV_RST};

	// control bits
	always_ff @(posedge clk) begin
		if (!rstn) begin
			override_q <= OVERRIDE_RST;
		end else if (mgmt_wr && mgmt_addr == REG_EXT_CTRL) begin
			override_q <= mgmt_wdata[EXT_OVERRIDE_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			jab_en_q <= JAB_EN_RST;
		end else if (mgmt_wr && mgmt_addr == REG_TEN_OPS) begin
			jab_en_q <= mgmt_wdata[TEN_JAB_EN_BIT];
		end
	end

	// identifier registers: writes silently dropped while override is off
	always_ff @(posedge clk) begin
		if (!rstn) begin
			id_high_q <= id_high_rst;
		end else if (mgmt_wr && override_q &&
		             mgmt_addr == REG_ID_HIGH) begin
			id_high_q <= mgmt_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			id_low_q <= id_low_rst;
		end else if (mgmt_wr && override_q &&
		             mgmt_addr == REG_ID_LOW) begin
			id_low_q <= mgmt_wdata;
		end
	end

	// jabber flag, shared by the basic and detailed status registers
	assign flag_clear = mgmt_rd &&
		(mgmt_addr == REG_STATUS || mgmt_addr == REG_DETAIL);

	pjsid_latch_high_flag u_jab_flag (
		.clk      (clk),
		.rstn     (rstn),
		.enable   (jab_en_q),
		.event_in (jabber_event),
		.clear    (flag_clear),
		.flag_q   (jab_flag)
	);

	// read mux; unmapped addresses and reserved bits read zero
	always_comb begin
		rdata_d = ZERO_WORD;
		unique case (mgmt_addr)
			REG_STATUS: begin
				rdata_d[STATUS_JAB_BIT]    = jab_flag;
				rdata_d[STATUS_EXTCAP_BIT] = 1'b1;
			end
			REG_ID_HIGH:  rdata_d = id_high_q;
			REG_ID_LOW:   rdata_d = id_low_q;
			REG_EXT_CTRL: rdata_d[EXT_OVERRIDE_BIT] = override_q;
			REG_DETAIL:   rdata_d[DETAIL_JAB_BIT] = jab_flag;
			REG_TEN_OPS:  rdata_d[TEN_JAB_EN_BIT] = jab_en_q;
			default:      rdata_d = ZERO_WORD;
		endcase
	end

	// read data is captured in the same edge that clears the flag
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q  <= ZERO_WORD;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= mgmt_rd;
			if (mgmt_rd) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign mgmt_rdata       = rdata_q;
	assign mgmt_rvalid      = rvalid_q;
	assign jabber_detect_en = jab_en_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_inhibit_zero;
		!jab_en_q |=> !jab_flag;
	endproperty
	a_inhibit_zero: assert property (p_inhibit_zero)
		else $error("jabber flag set while detection disabled");

	property p_jab_set;
		jab_en_q && jabber_event |=> jab_flag;
	endproperty
	a_jab_set: assert property (p_jab_set)
		else $error("jabber event did not set flag");

	property p_jab_hold;
		jab_flag && jab_en_q && !mgmt_rd ##1 jab_en_q && !mgmt_rd
			|=> jab_flag;
	endproperty
	a_jab_hold: assert property (p_jab_hold)
		else $error("jabber flag dropped without a read");

	property p_detail_clear;
		mgmt_rd && mgmt_addr == REG_DETAIL && !jabber_event |=> !jab_flag;
	endproperty
	a_detail_clear: assert property (p_detail_clear)
		else $error("detailed status read did not clear flag");

	property p_read_then_clear;
		mgmt_rd && mgmt_addr == REG_STATUS
			|=> mgmt_rvalid && mgmt_rdata[STATUS_JAB_BIT] == $past(jab_flag);
	endproperty
	a_read_then_clear: assert property (p_read_then_clear)
		else $error("status read lost latched jabber value");

	property p_extcap;
		mgmt_rd && mgmt_addr == REG_STATUS
			|=> mgmt_rdata[STATUS_EXTCAP_BIT];
	endproperty
	a_extcap: assert property (p_extcap)
		else $error("extended capability bit read zero");

	property p_id_gate;
		mgmt_wr && !override_q && mgmt_addr == REG_ID_HIGH
			|=> $stable(id_high_q);
	endproperty
	a_id_gate: assert property (p_id_gate)
		else $error("identifier written while override off");

	property p_id_write;
		mgmt_wr && override_q && mgmt_addr == REG_ID_LOW
			|=> id_low_q == $past(mgmt_wdata);
	endproperty
	a_id_write: assert property (p_id_write)
		else $error("identifier write with override was lost");

	property p_id_read;
		mgmt_rd && mgmt_addr == REG_ID_HIGH
			|=> mgmt_rvalid && mgmt_rdata == $past(id_high_q);
	endproperty
	a_id_read: assert property (p_id_read)
		else $error("identifier read returned wrong value");

	property p_id_reset;
		disable iff (1'b0)
		!rstn |=> id_low_q[9:0] == {MODEL_RST, REV_RST}
			&& id_high_q == id_high_rst;
	endproperty
	a_id_reset: assert property (p_id_reset)
		else $error("identifier reset image wrong");

	c_jab_read: cover property (jab_flag && flag_clear);
	c_jab_collide: cover property (jab_flag && flag_clear && jabber_event);
	c_id_write: cover property (mgmt_wr && override_q &&
	                            mgmt_addr == REG_ID_HIGH);
	c_id_drop: cover property (mgmt_wr && !override_q &&
	                           mgmt_addr == REG_ID_LOW);

endmodule : pjsid_regs

`default_nettype wire

// >>> sim/pjsid_sta_model.sv
// pjsid_sta_model: management entity that issues one-cycle strobes.
// assumes the bank answers a read exactly one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none

module pjsid_sta_model (
	// clock
	input  wire logic        clk,
	// management access
	output var  logic        mgmt_rd,
	output var  logic        mgmt_wr,
	output var  logic [4:0]  mgmt_addr,
	output var  logic [15:0] mgmt_wdata,
	input  wire logic [15:0] mgmt_rdata,
	input  wire logic        mgmt_rvalid
);
	initial begin
		mgmt_rd = 1'b0;
		mgmt_wr = 1'b0;
		mgmt_addr = 5'h00;
		mgmt_wdata = 16'h0000;
	end

	// callers put zero, the default, in every reserved bit
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		mgmt_wr <= 1'b1;
		mgmt_addr <= a;
		mgmt_wdata <= d;
		@(posedge clk);
		mgmt_wr <= 1'b0;
		// released lines must not keep showing the last value
		mgmt_addr <= ~a;
		mgmt_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		mgmt_rd <= 1'b1;
		mgmt_addr <= a;
		@(posedge clk);
		mgmt_rd <= 1'b0;
		mgmt_addr <= ~a;
		// answer stands for this one cycle; take it at the next edge
		@(posedge clk);
		d = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 16'hxxxx;
	endtask : rd
endmodule : pjsid_sta_model
`default_nettype wire

// >>> sim/tb_top.sv
// tb_top: self-checking bench for the jabber status and id bank.
// assumes pjsid_regs and pjsid_sta_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import pjsid_pkg::*;
;
	localparam logic [23:0] OUI = 24'h5A_C30F; // arbitrary vendor code
	// id image of OUI worked by hand: octets 5a c3 0f, each lsb first
	localparam logic [15:0] ID_HIGH_EXP = 16'h6B0F;
	localparam logic [15:0] ID_LOW_EXP  = {6'h30, MODEL_RST, REV_RST};
	logic        clk;
	logic        rstn;
	logic        jab;
	logic        rd;
	logic        wr;
	logic        rvalid;
	logic        jab_en;
	logic [4:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	int          fail_count;
	int          comparisons;

	pjsid_regs #(.OUI_VALUE(OUI)) pjsid_regs_inst (.clk(clk), .rstn(rstn),
		.mgmt_rd(rd), .mgmt_wr(wr), .mgmt_addr(addr), .mgmt_wdata(wdata),
		.mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .jabber_event(jab),
		.jabber_detect_en(jab_en));
	pjsid_sta_model pjsid_sta_model_inst (.clk(clk), .mgmt_rd(rd),
		.mgmt_wr(wr), .mgmt_addr(addr), .mgmt_wdata(wdata),
		.mgmt_rdata(rdata), .mgmt_rvalid(rvalid));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string s, input logic [15:0] g, e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask : check

	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] d;
		pjsid_sta_model_inst.rd(a, d);
		check($sformatf("reg %0h", a), d, e);
	endtask : rdc

	task automatic w(input logic [4:0] a, input logic [15:0] d);
		pjsid_sta_model_inst.wr(a, d);
	endtask : w

	task automatic pulse();
		@(posedge clk);
		jab <= 1'b1;
		@(posedge clk);
		jab <= 1'b0;
	endtask : pulse

	task automatic reset_dut();
		rstn <= 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
	endtask : reset_dut

	task automatic t_reset();
		rdc(REG_ID_HIGH, ID_HIGH_EXP);
		rdc(REG_ID_LOW, ID_LOW_EXP);
		rdc(REG_STATUS, 16'h0001);
		rdc(REG_TEN_OPS, 16'h0001 << TEN_JAB_EN_BIT);
		rdc(5'h1F, ZERO_WORD);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_id_write();
		w(REG_ID_HIGH, 16'hBEEF);
		rdc(REG_ID_HIGH, ID_HIGH_EXP);
		w(REG_EXT_CTRL, 16'h8000);
		w(REG_ID_HIGH, 16'h1234);
		w(REG_ID_LOW, 16'hFEDC);
		rdc(REG_ID_HIGH, 16'h1234);
		rdc(REG_ID_LOW, 16'hFEDC);
		w(REG_EXT_CTRL, ZERO_WORD);
		w(REG_ID_LOW, ZERO_WORD);
		rdc(REG_ID_LOW, 16'hFEDC);
		// a second reset must bring back the fixed image
		reset_dut();
		rdc(REG_ID_LOW, ID_LOW_EXP);
		$display("t_id_write done");
	endtask : t_id_write

	task automatic t_jabber();
		pulse();
		repeat (3) @(posedge clk);
		rdc(REG_STATUS, 16'h0003);
		rdc(REG_STATUS, 16'h0001);
		pulse();
		rdc(REG_DETAIL, 16'h0004);
		rdc(REG_STATUS, 16'h0001);
		// event in the very read cycle must survive the clear
		fork
			rdc(REG_STATUS, 16'h0001);
			pulse();
		join
		rdc(REG_STATUS, 16'h0003);
		pulse();
		w(REG_TEN_OPS, ZERO_WORD);
		#1;
		check("jab_en", {15'h0000, jab_en}, ZERO_WORD);
		pulse();
		rdc(REG_STATUS, 16'h0001);
		w(REG_TEN_OPS, 16'h0001 << TEN_JAB_EN_BIT);
		pulse();
		rdc(REG_STATUS, 16'h0003);
		$display("t_jabber done");
	endtask : t_jabber

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		rstn = 1'b0;
		jab = 1'b0;
		fail_count = 0;
		comparisons = 0;
		reset_dut();
		t_reset();
		t_id_write();
		t_jabber();
		conclude();
	end

	// tests need some 125 cycles; the 2000-cycle limit, sixteen times that, means a hang
	initial begin
		#20000;
		fail_count++;
		conclude();
	end
endmodule : tb_top
`default_nettype wire
